// ### logic/acsw_map.svh
`ifndef ACSW_MAP_SVH
`define ACSW_MAP_SVH
// control word bit positions
`define ACSW_B_MOVE_START 0
`define ACSW_B_HOME 1
`define ACSW_B_PAUSE 2
`define ACSW_B_FAULT_CLR 3
`define ACSW_B_DRIVE_EN 4
`define ACSW_B_INCH_SEL 5
`define ACSW_B_JOG_PROF 6
`define ACSW_B_JOG_MINUS 7
`define ACSW_B_JOG_PLUS 8
// status word bit positions
`define ACSW_S_IN_POS 0
`define ACSW_S_HOME_END 1
`define ACSW_S_MOVING 2
`define ACSW_S_FAULT 3
`define ACSW_S_STANDBY 14
`define ACSW_S_ESTOP 15
// word width and reset values
`define ACSW_WORD_W 16
`define ACSW_WORD_ZERO 16'h0000
`define ACSW_SYNC_W 33
`define ACSW_SYNC_ZERO 33'h000000000
`endif

// ### logic/acsw_pkg.sv
package acsw_pkg;
  // axis command sequencer states
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_homing = 2'b01,
    st_moving = 2'b10
  } acsw_state_t;
endpackage

// ### logic/acsw_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser, one chain per bit
module acsw_sync #(
  parameter int WIDTH = 33
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
      logic [1:0] sh_reg; // stage 0 feeds only stage 1
      logic [1:0] sh_next;
      // shift the pin level in
      always_comb begin
        sh_next = {sh_reg[0], din[gi]};
      end
      // register both stages
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          sh_reg <= 2'h0;
        end else begin
          sh_reg <= sh_next;
        end
      end
      assign dout[gi] = sh_reg[1];
    end
  endgenerate
endmodule // acsw_sync

// ### logic/acsw_axis_ctrl.sv
// Function
// [RULE1] plus jog bit drives away from home
// [RULE2] minus jog bit drives toward home
// [RULE3] profile bit low picks first speed/distance
// [RULE4] profile bit high picks second speed/distance
// [RULE5] inch bit picks steps, else continuous jog
// [RULE6] enable bit switches servo on and off
// [RULE7] fault clear bit rising resets controller
// [RULE8] pause bit holds motion while set
// [RULE9] home return runs to completion once started
// [RULE10] positioning move runs to completion once started
// [RULE11] completed word shows target once in width
// [RULE12] completed word zero before moves, during move
// [RULE13] plc reads completed word after in_position
// [RULE14] alarm code replaces position during fault
// [RULE15] status bit 15 shows emergency stop
// [RULE16] status bit 14 shows standby
// [RULE17] status bit 3 shows alarm present
// [RULE18] only rising edges trigger reset/home/start
`timescale 1ns/1ps
`include "acsw_map.svh"
module acsw_axis_ctrl #(
  parameter int SPD_W = 16,
  parameter int DST_W = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [15:0] axis_control_word,
  input wire logic [15:0] target_position_no,
  input wire logic estop_in,
  input wire logic [SPD_W-1:0] jog_speed_1,
  input wire logic [SPD_W-1:0] jog_speed_2,
  input wire logic [DST_W-1:0] inch_dist_1,
  input wire logic [DST_W-1:0] inch_dist_2,
  input wire logic alarm_present,
  input wire logic [15:0] alarm_code,
  input wire logic axis_in_width,
  input wire logic home_found,
  output logic [15:0] completed_position_word,
  output logic [15:0] axis_status_word,
  output logic jog_fwd,
  output logic jog_rev,
  output logic inch_step_fwd,
  output logic inch_step_rev,
  output logic [SPD_W-1:0] jog_speed,
  output logic [DST_W-1:0] inch_distance,
  output logic servo_on,
  output logic ctrl_reset,
  output logic motion_pause,
  output logic home_run,
  output logic move_run,
  output logic [15:0] move_target
);
  // synchronised gateway words and estop pin
  logic [`ACSW_SYNC_W-1:0] sync_out;
  logic [15:0] ctl; // control word, own clock
  logic [15:0] tgt; // requested position number
  logic estop; // emergency stop level

  acsw_sync #(
    .WIDTH(`ACSW_SYNC_W)
  ) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .din({estop_in, target_position_no, axis_control_word}),
    .dout(sync_out)
  );
  assign ctl = sync_out[15:0];
  assign tgt = sync_out[31:16];
  assign estop = sync_out[32];

  // registered state
  acsw_pkg::acsw_state_t state_reg, state_next;
  logic [15:0] ctl_prev_reg, ctl_prev_next; // for edge detection
  logic [15:0] target_reg, target_next; // latched target
  logic [15:0] comp_pos_reg, comp_pos_next; // last completed position
  logic in_pos_reg, in_pos_next;
  logic home_end_reg, home_end_next;
  logic [15:0] comp_word_reg, comp_word_next;
  logic [15:0] status_reg, status_next;
  logic jog_fwd_reg, jog_fwd_next;
  logic jog_rev_reg, jog_rev_next;
  logic inch_fwd_reg, inch_fwd_next;
  logic inch_rev_reg, inch_rev_next;
  logic [SPD_W-1:0] jog_speed_reg, jog_speed_next;
  logic [DST_W-1:0] inch_dist_reg, inch_dist_next;
  logic servo_reg, servo_next;
  logic ctrl_reset_reg, ctrl_reset_next;
  logic pause_reg, pause_next;
  logic home_run_reg, home_run_next;
  logic move_run_reg, move_run_next;

  // edges and run permission
  logic rise_clr, rise_home, rise_move, rise_plus, rise_minus;
  logic ok_run; // servo on, no alarm, no estop
  logic abort; // drops any move in progress
  logic jog_ok; // manual motion allowed

  always_comb begin
    // only a fresh turn-on counts; a held bit does nothing
    rise_clr = ctl[`ACSW_B_FAULT_CLR] & ~ctl_prev_reg[`ACSW_B_FAULT_CLR]; // see [RULE18]
    rise_home = ctl[`ACSW_B_HOME] & ~ctl_prev_reg[`ACSW_B_HOME]; // see [RULE18]
    rise_move = ctl[`ACSW_B_MOVE_START]
      & ~ctl_prev_reg[`ACSW_B_MOVE_START]; // see [RULE18]
    rise_plus = ctl[`ACSW_B_JOG_PLUS] & ~ctl_prev_reg[`ACSW_B_JOG_PLUS];
    rise_minus = ctl[`ACSW_B_JOG_MINUS] & ~ctl_prev_reg[`ACSW_B_JOG_MINUS];
    ok_run = ctl[`ACSW_B_DRIVE_EN] & ~alarm_present & ~estop;
    abort = ~ok_run | rise_clr;
    jog_ok = ok_run & (state_reg == acsw_pkg::st_idle)
      & ~ctl[`ACSW_B_PAUSE];
  end

  // command sequencer next values
  always_comb begin
    state_next = state_reg;
    target_next = target_reg;
    comp_pos_next = comp_pos_reg;
    in_pos_next = in_pos_reg;
    home_end_next = home_end_reg;
    ctl_prev_next = ctl;
    case (state_reg)
      acsw_pkg::st_idle: begin
        // home wins when both start bits rise together
        if (ok_run && !rise_clr && rise_home) begin
          state_next = acsw_pkg::st_homing; // see [RULE9]
          comp_pos_next = `ACSW_WORD_ZERO; // see [RULE12]
          in_pos_next = 1'b0;
          home_end_next = 1'b0;
        end else if (ok_run && !rise_clr && rise_move) begin
          state_next = acsw_pkg::st_moving; // see [RULE10]
          target_next = tgt;
          comp_pos_next = `ACSW_WORD_ZERO; // see [RULE12]
          in_pos_next = 1'b0;
        end
      end
      acsw_pkg::st_homing: begin
        // the home bit is not watched here: run carries on
        if (abort) begin
          state_next = acsw_pkg::st_idle;
        end else if (home_found && !ctl[`ACSW_B_PAUSE]) begin
          state_next = acsw_pkg::st_idle; // see [RULE9]
          home_end_next = 1'b1;
          in_pos_next = 1'b1;
        end
      end
      acsw_pkg::st_moving: begin
        // completion is held off while paused
        if (abort) begin
          state_next = acsw_pkg::st_idle;
        end else if (axis_in_width && !ctl[`ACSW_B_PAUSE]) begin
          state_next = acsw_pkg::st_idle; // see [RULE10]
          comp_pos_next = target_reg; // see [RULE11]
          in_pos_next = 1'b1;
        end
      end
      default: begin
        state_next = acsw_pkg::st_idle;
      end
    endcase
    // completion flag drops with the servo
    if (!ctl[`ACSW_B_DRIVE_EN]) begin
      in_pos_next = 1'b0;
    end
  end

  // manual motion, drive commands and words
  always_comb begin
    // continuous jog only in jog mode, released on bit low
    jog_fwd_next = jog_ok & ~ctl[`ACSW_B_INCH_SEL] & ctl[`ACSW_B_JOG_PLUS]
      & ~ctl[`ACSW_B_JOG_MINUS]; // see [RULE1] [RULE5]
    jog_rev_next = jog_ok & ~ctl[`ACSW_B_INCH_SEL] & ctl[`ACSW_B_JOG_MINUS]
      & ~ctl[`ACSW_B_JOG_PLUS]; // see [RULE2] [RULE5]
    // one step per turn-on in inching mode
    inch_fwd_next = jog_ok & ctl[`ACSW_B_INCH_SEL] & rise_plus; // see [RULE5]
    inch_rev_next = jog_ok & ctl[`ACSW_B_INCH_SEL] & rise_minus; // see [RULE5]
    // speed and distance pairs are chosen together
    if (ctl[`ACSW_B_JOG_PROF]) begin
      jog_speed_next = jog_speed_2; // see [RULE4]
      inch_dist_next = inch_dist_2; // see [RULE4]
    end else begin
      jog_speed_next = jog_speed_1; // see [RULE3]
      inch_dist_next = inch_dist_1; // see [RULE3]
    end
    servo_next = ctl[`ACSW_B_DRIVE_EN]; // see [RULE6]
    ctrl_reset_next = rise_clr; // see [RULE7]
    pause_next = ctl[`ACSW_B_PAUSE]; // see [RULE8]
    home_run_next = (state_next == acsw_pkg::st_homing);
    move_run_next = (state_next == acsw_pkg::st_moving);
    // alarm code takes over the position word
    if (alarm_present) begin
      comp_word_next = alarm_code; // see [RULE14]
    end else begin
      comp_word_next = comp_pos_next; // see [RULE11] [RULE12]
    end
    // unused status bits read as zero
    status_next = `ACSW_WORD_ZERO;
    status_next[`ACSW_S_ESTOP] = estop; // see [RULE15]
    status_next[`ACSW_S_STANDBY] = ok_run; // see [RULE16]
    status_next[`ACSW_S_FAULT] = alarm_present; // see [RULE17]
    status_next[`ACSW_S_MOVING] = home_run_next | move_run_next
      | jog_fwd_next | jog_rev_next;
    status_next[`ACSW_S_HOME_END] = home_end_next;
    status_next[`ACSW_S_IN_POS] = in_pos_next;
  end

  // register everything
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= acsw_pkg::st_idle;
      ctl_prev_reg <= `ACSW_WORD_ZERO;
      target_reg <= `ACSW_WORD_ZERO;
      comp_pos_reg <= `ACSW_WORD_ZERO;
      in_pos_reg <= 1'b0;
      home_end_reg <= 1'b0;
      comp_word_reg <= `ACSW_WORD_ZERO;
      status_reg <= `ACSW_WORD_ZERO;
      jog_fwd_reg <= 1'b0;
      jog_rev_reg <= 1'b0;
      inch_fwd_reg <= 1'b0;
      inch_rev_reg <= 1'b0;
      jog_speed_reg <= '0;
      inch_dist_reg <= '0;
      servo_reg <= 1'b0;
      ctrl_reset_reg <= 1'b0;
      pause_reg <= 1'b0;
      home_run_reg <= 1'b0;
      move_run_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ctl_prev_reg <= ctl_prev_next;
      target_reg <= target_next;
      comp_pos_reg <= comp_pos_next;
      in_pos_reg <= in_pos_next;
      home_end_reg <= home_end_next;
      comp_word_reg <= comp_word_next;
      status_reg <= status_next;
      jog_fwd_reg <= jog_fwd_next;
      jog_rev_reg <= jog_rev_next;
      inch_fwd_reg <= inch_fwd_next;
      inch_rev_reg <= inch_rev_next;
      jog_speed_reg <= jog_speed_next;
      inch_dist_reg <= inch_dist_next;
      servo_reg <= servo_next;
      ctrl_reset_reg <= ctrl_reset_next;
      pause_reg <= pause_next;
      home_run_reg <= home_run_next;
      move_run_reg <= move_run_next;
    end
  end

  // outputs straight from flops
  assign completed_position_word = comp_word_reg;
  assign axis_status_word = status_reg;
  assign jog_fwd = jog_fwd_reg;
  assign jog_rev = jog_rev_reg;
  assign inch_step_fwd = inch_fwd_reg;
  assign inch_step_rev = inch_rev_reg;
  assign jog_speed = jog_speed_reg;
  assign inch_distance = inch_dist_reg;
  assign servo_on = servo_reg;
  assign ctrl_reset = ctrl_reset_reg;
  assign motion_pause = pause_reg;
  assign home_run = home_run_reg;
  assign move_run = move_run_reg;
  assign move_target = target_reg;

  // checks on the command interpreter
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  property p_jog_plus;
    ctl[`ACSW_B_JOG_PLUS] && !ctl[`ACSW_B_JOG_MINUS]
      && !ctl[`ACSW_B_INCH_SEL] && jog_ok |=> jog_fwd_reg && status_reg[2];
  endproperty
  a_jog_plus: assert property (p_jog_plus) // see [RULE1]
    else $error("plus jog not driven");
  property p_jog_minus_stop;
    !ctl[`ACSW_B_JOG_MINUS] |=> !jog_rev_reg;
  endproperty
  a_jog_minus_stop: assert property (p_jog_minus_stop) // see [RULE2]
    else $error("minus jog not stopped");
  property p_prof_first;
    !ctl[`ACSW_B_JOG_PROF] |=> jog_speed_reg == $past(jog_speed_1)
      && inch_dist_reg == $past(inch_dist_1);
  endproperty
  a_prof_first: assert property (p_prof_first) // see [RULE3]
    else $error("first profile not used");
  property p_prof_second;
    ctl[`ACSW_B_JOG_PROF] |=> jog_speed_reg == $past(jog_speed_2)
      && inch_dist_reg == $past(inch_dist_2);
  endproperty
  a_prof_second: assert property (p_prof_second) // see [RULE4]
    else $error("second profile not used");
  property p_inch_no_jog;
    ctl[`ACSW_B_INCH_SEL] |=> !jog_fwd_reg && !jog_rev_reg;
  endproperty
  a_inch_no_jog: assert property (p_inch_no_jog) // see [RULE5]
    else $error("continuous jog in inching mode");
  property p_servo;
    ##1 servo_reg == $past(ctl[`ACSW_B_DRIVE_EN]);
  endproperty
  a_servo: assert property (p_servo) // see [RULE6]
    else $error("servo does not follow enable");
  property p_reset_pulse;
    rise_clr |=> ctrl_reset_reg && state_reg == acsw_pkg::st_idle
      ##1 !ctrl_reset_reg;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) // see [RULE7] [RULE18]
    else $error("reset pulse wrong");
  property p_pause_hold;
    state_reg == acsw_pkg::st_moving && ctl[`ACSW_B_PAUSE] && !abort
      |=> state_reg == acsw_pkg::st_moving && pause_reg;
  endproperty
  a_pause_hold: assert property (p_pause_hold) // see [RULE8]
    else $error("move ended while paused");
  property p_home_runs;
    state_reg == acsw_pkg::st_homing && !home_found && !abort
      |=> home_run_reg;
  endproperty
  a_home_runs: assert property (p_home_runs) // see [RULE9]
    else $error("home return dropped");
  property p_move_runs;
    state_reg == acsw_pkg::st_moving && !axis_in_width && !abort
      |=> move_run_reg && completed_position_word == 16'h0000;
  endproperty
  a_move_runs: assert property (p_move_runs) // see [RULE10] [RULE12]
    else $error("move dropped or word not zero");
  property p_done_word;
    state_reg == acsw_pkg::st_moving && axis_in_width
      && !ctl[`ACSW_B_PAUSE] && !abort
      |=> completed_position_word == $past(target_reg) && status_reg[0];
  endproperty
  a_done_word: assert property (p_done_word) // see [RULE11]
    else $error("completed position not reported");
  property p_start_zero;
    $rose(move_run_reg) |-> completed_position_word == 16'h0000;
  endproperty
  a_start_zero: assert property (p_start_zero) // see [RULE12]
    else $error("word not zero at move start");
  property p_alarm_word;
    alarm_present |=> completed_position_word == $past(alarm_code)
      && status_reg[3] && !status_reg[14];
  endproperty
  a_alarm_word: assert property (p_alarm_word) // see [RULE14] [RULE17]
    else $error("alarm code or flag missing");
  property p_estop;
    estop |=> status_reg[15] && !move_run_reg && !home_run_reg;
  endproperty
  a_estop: assert property (p_estop) // see [RULE15]
    else $error("estop not reported");
  property p_standby;
    ok_run |=> status_reg[14];
  endproperty
  a_standby: assert property (p_standby) // see [RULE16]
    else $error("standby not reported");
  property p_held_no_retrig;
    ctl[`ACSW_B_FAULT_CLR] && ctl_prev_reg[`ACSW_B_FAULT_CLR]
      |=> !ctrl_reset_reg;
  endproperty
  a_held_no_retrig: assert property (p_held_no_retrig) // see [RULE18]
    else $error("held clear bit retriggered");

  c_move_done: cover property (move_run_reg ##1 status_reg[0]);
  c_home_done: cover property (home_run_reg ##1 status_reg[1]);
  c_alarm: cover property (status_reg[3] ##1 ctrl_reset_reg);
  c_inch: cover property (inch_step_fwd);
endmodule // acsw_axis_ctrl

// ### tb/acsw_plc_model.sv
`timescale 1ns/1ps
`include "acsw_map.svh"
// plc master behind the gateway: writes control words, reads results
module acsw_plc_model (
  input wire logic clock,
  input wire logic [15:0] completed_position_word,
  input wire logic [15:0] axis_status_word,
  output logic [15:0] axis_control_word,
  output logic [15:0] target_position_no
);
  // words start cleared, as after a fieldbus link-up
  initial begin
    axis_control_word = 16'h0000;
    target_position_no = 16'h0000;
  end
  // refresh both words just after an edge, never on it
  task automatic put(input logic [15:0] ctl, input logic [15:0] tgt);
    @(posedge clock);
    #1;
    target_position_no = tgt;
    axis_control_word = ctl;
  endtask
  // the position word is trusted only once in-position is up
  task automatic get_pos(output logic [15:0] pos, output logic ok);
    ok = (axis_status_word[`ACSW_S_IN_POS] === 1'b1);
    pos = ok ? completed_position_word : 16'h0000;
  endtask
endmodule // acsw_plc_model

// ### tb/axis_control_status_words_tb_top.sv
`timescale 1ns/1ps
`include "acsw_map.svh"
`define ACSW_CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin \
  n_errors++; $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); \
  end end
module axis_control_status_words_tb_top;
  logic clock, rst_n, estop_in, alarm_present, axis_in_width, home_found;
  logic [15:0] js1, js2, id1, id2, alarm_code, cpw, stat, mtgt, pos;
  logic [15:0] jspd, idst;
  wire logic [15:0] ctl, tgt;
  logic jf, jr, isf, isr, drive_enable_cmd, crst, mpause, hrun, mrun, ok;
  int n_errors, cmp_count, k, pulses, m_cpw;
  logic [7:0] lfsr;
  // reference state: alarm, estop, enable
  logic m_alm, m_est, m_en;
  logic [15:0] t;
  acsw_plc_model i_plc (.clock(clock), .completed_position_word(cpw),
    .axis_status_word(stat), .axis_control_word(ctl),
    .target_position_no(tgt));
  acsw_axis_ctrl i_dut (.clock(clock), .rst_n(rst_n),
    .axis_control_word(ctl), .target_position_no(tgt), .estop_in(estop_in),
    .jog_speed_1(js1), .jog_speed_2(js2), .inch_dist_1(id1),
    .inch_dist_2(id2), .alarm_present(alarm_present),
    .alarm_code(alarm_code), .axis_in_width(axis_in_width),
    .home_found(home_found), .completed_position_word(cpw),
    .axis_status_word(stat), .jog_fwd(jf), .jog_rev(jr),
    .inch_step_fwd(isf), .inch_step_rev(isr), .jog_speed(jspd),
    .inch_distance(idst), .servo_on(drive_enable_cmd), .ctrl_reset(crst),
    .motion_pause(mpause), .home_run(hrun), .move_run(mrun),
    .move_target(mtgt));
  // 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // random source, seeded at 92
  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // verdict, reached from the end and from any expired wait
  task automatic complete_run();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // bounded wait for a level; expiry is a mismatch
  task automatic wait_hi(ref logic s);
    for (k = 0; k < 20 && s !== 1'b1; k++) cyc(1);
    if (s !== 1'b1) begin
      n_errors++;
      $display("CHECK FAILED t=%0t wait expired", $time);
      complete_run();
    end
  endtask
  // count one-cycle pulses over a window, since pulses are short
  task automatic count(ref logic s, input int n);
    pulses = 0;
    repeat (n) begin
      cyc(1);
      if (s === 1'b1) pulses++;
    end
  endtask
  // reference words: position/alarm, estop, standby, alarm flag
  task automatic chk_words();
    `ACSW_CHK(cpw, m_alm ? alarm_code : m_cpw[15:0])
    `ACSW_CHK(stat[`ACSW_S_ESTOP], m_est)
    `ACSW_CHK(stat[`ACSW_S_STANDBY], m_en & ~m_alm & ~m_est)
    `ACSW_CHK(stat[`ACSW_S_FAULT], m_alm)
  endtask
  initial begin
    rst_n = 1'b0;
    {estop_in, alarm_present, axis_in_width, home_found} = 4'h0;
    lfsr = 8'h5c;
    n_errors = 0;
    cmp_count = 0;
    {m_alm, m_est, m_en} = 3'b000;
    m_cpw = 0;
    lfsr = nxt(lfsr);
    js1 = {8'h00, lfsr};
    lfsr = nxt(lfsr);
    js2 = {8'h01, lfsr};
    lfsr = nxt(lfsr);
    id1 = {8'h02, lfsr};
    lfsr = nxt(lfsr);
    id2 = {8'h03, lfsr};
    alarm_code = 16'h00a2;
    cyc(5);
    rst_n = 1'b1;
    chk_words();
    // servo on, standby shows
    i_plc.put(16'h0010, 16'h0000);
    cyc(4);
    m_en = 1'b1;
    `ACSW_CHK(drive_enable_cmd, 1'b1)
    chk_words();
    // move, start bit dropped while running
    lfsr = nxt(lfsr);
    t = {6'h00, lfsr[1:0], nxt(lfsr)};
    i_plc.put(16'h0010, t);
    cyc(3);
    i_plc.put(16'h0011, t);
    wait_hi(mrun);
    `ACSW_CHK(mtgt, t)
    i_plc.put(16'h0010, t);
    cyc(5);
    `ACSW_CHK(mrun, 1'b1)
    `ACSW_CHK(stat[`ACSW_S_MOVING], 1'b1)
    chk_words();
    axis_in_width = 1'b1;
    cyc(2);
    m_cpw = t;
    `ACSW_CHK(stat[`ACSW_S_IN_POS], 1'b1)
    i_plc.get_pos(pos, ok);
    `ACSW_CHK(pos, t)
    chk_words();
    axis_in_width = 1'b0;
    // home, bit cleared on the way
    i_plc.put(16'h0012, t);
    wait_hi(hrun);
    i_plc.put(16'h0010, t);
    cyc(5);
    `ACSW_CHK(hrun, 1'b1)
    home_found = 1'b1;
    cyc(1);
    home_found = 1'b0;
    cyc(1);
    m_cpw = 0;
    `ACSW_CHK(stat[`ACSW_S_HOME_END], 1'b1)
    chk_words();
    // jog both ways under both profiles
    for (int p = 0; p < 2; p++) begin
      i_plc.put(16'h0110 | 16'(p << 6), t);
      cyc(4);
      `ACSW_CHK({jf, jr}, 2'b10)
      `ACSW_CHK(jspd, p ? js2 : js1)
      `ACSW_CHK(idst, p ? id2 : id1)
      i_plc.put(16'h0090 | 16'(p << 6), t);
      cyc(4);
      `ACSW_CHK({jf, jr}, 2'b01)
    end
    // pause stops the jog
    i_plc.put(16'h0114, t);
    cyc(4);
    `ACSW_CHK({mpause, jf}, 2'b10)
    i_plc.put(16'h0010, t);
    cyc(4);
    `ACSW_CHK(mpause, 1'b0)
    // inching gives single steps, no continuous jog
    i_plc.put(16'h0030, t);
    cyc(4);
    i_plc.put(16'h0130, t);
    count(isf, 8);
    `ACSW_CHK(pulses, 1)
    `ACSW_CHK(jf, 1'b0)
    // reverse step: one pulse per minus turn-on
    i_plc.put(16'h0030, t);
    cyc(4);
    i_plc.put(16'h00b0, t);
    count(isr, 8);
    `ACSW_CHK(pulses, 1)
    `ACSW_CHK(jr, 1'b0)
    // fault clear held high pulses reset only once
    i_plc.put(16'h0018, t);
    count(crst, 10);
    `ACSW_CHK(pulses, 1)
    i_plc.put(16'h0010, t);
    // emergency stop
    estop_in = 1'b1;
    cyc(4);
    m_est = 1'b1;
    chk_words();
    estop_in = 1'b0;
    cyc(4);
    m_est = 1'b0;
    chk_words();
    // alarm replaces the position word
    alarm_present = 1'b1;
    cyc(2);
    m_alm = 1'b1;
    chk_words();
    // servo off
    i_plc.put(16'h0000, t);
    cyc(4);
    `ACSW_CHK(drive_enable_cmd, 1'b0)
    complete_run();
  end
endmodule // axis_control_status_words_tb_top
